// File: sim/parallel_move_execution_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module parallel_move_execution_tb_top;
   logic clk_i = 0, rst_i = 1, valid_i = 0, write1_i = 0, pspace_i = 0;
   logic [2:0] cls_i = 0, amode_i = 0;
   logic [1:0] alu_op_i = 0, alu_dst_i = 0, alu_src_i = 0, ptr1_sel_i = 0;
   logic [1:0] upd1_i = 0, upd2_i = 0, reg1_i = 0, reg2_i = 0;
   logic [15:0] abs_addr_i = 0;
   wire [15:0] core_global_data_bus_i, secondary_data_bus_i, prog_data_i;
   wire [15:0] primary_data_address_bus_o, secondary_data_address_bus_o;
   wire [15:0] core_global_data_bus_o, prog_addr_o, prog_data_o;
   wire [15:0] reg0_o, reg1_o, pointer_zero_o, pointer_three_o;
   wire xrd1_o, xwr1_o, xrd2_o, prd_o, pwr_o, accept_o, illegal_o;
   int num_errors = 0, total_checks = 0;
   always #4 clk_i = ~clk_i;
   pmx_core dut (
      .clk_i(clk_i), .rst_i(rst_i), .valid_i(valid_i), .cls_i(cls_i),
      .alu_op_i(alu_op_i), .alu_dst_i(alu_dst_i), .alu_src_i(alu_src_i),
      .ptr1_sel_i(ptr1_sel_i), .upd1_i(upd1_i), .reg1_i(reg1_i),
      .write1_i(write1_i), .pspace_i(pspace_i), .amode_i(amode_i),
      .abs_addr_i(abs_addr_i), .upd2_i(upd2_i), .reg2_i(reg2_i),
      .core_global_data_bus_i(core_global_data_bus_i),
      .secondary_data_bus_i(secondary_data_bus_i),
      .prog_data_i(prog_data_i),
      .primary_data_address_bus_o(primary_data_address_bus_o),
      .xrd1_o(xrd1_o), .xwr1_o(xwr1_o), .xrd2_o(xrd2_o),
      .core_global_data_bus_o(core_global_data_bus_o),
      .secondary_data_address_bus_o(secondary_data_address_bus_o),
      .prog_addr_o(prog_addr_o), .prd_o(prd_o), .pwr_o(pwr_o),
      .prog_data_o(prog_data_o), .accept_o(accept_o),
      .illegal_o(illegal_o), .reg0_o(reg0_o), .reg1_o(reg1_o),
      .pointer_zero_o(pointer_zero_o), .pointer_three_o(pointer_three_o));
   pmx_xmem_model u_mem (.rd1_i(xrd1_o), .rd2_i(xrd2_o), .prd_i(prd_o),
      .a1_i(primary_data_address_bus_o), .a2_i(secondary_data_address_bus_o),
      .pa_i(prog_addr_o), .d1_o(core_global_data_bus_i),
      .d2_o(secondary_data_bus_i), .pd_o(prog_data_i));
   function [15:0] mv(input [15:0] a);
      mv = {a[7:0], ~a[15:8]};
   endfunction
   task step;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task close_out;
      if (num_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task t_dual;
      logic [15:0] p0, p3;
      p0 = 0; p3 = 0;
      repeat (2) begin
         valid_i = 1; cls_i = 2; alu_op_i = 1; alu_dst_i = 2; upd1_i = 1;
         upd2_i = 2; reg1_i = 0; reg2_i = 1; #1;
         `CHK({xrd1_o, xrd2_o, accept_o}, 3'h7)
         `CHK({primary_data_address_bus_o, secondary_data_address_bus_o}, {p0, p3})
         step; #1;
         `CHK({reg0_o, reg1_o}, {mv(p0), mv(p3)})
         p0++; p3--;
         `CHK({pointer_zero_o, pointer_three_o}, {p0, p3})
      end
      valid_i = 0;
   endtask
   task t_refuse;
      for (int c = 4; c < 8; c++) begin
         valid_i = 1; cls_i = c[2:0]; #1;
         `CHK({illegal_o, accept_o, xrd1_o, xwr1_o, xrd2_o}, 5'h10)
         step;
      end
      cls_i = 1; alu_op_i = 0; #1;
      `CHK(illegal_o, 1'b1)
      step;
      cls_i = 2; alu_op_i = 1; upd2_i = 3; #1;
      `CHK(illegal_o, 1'b1)
      step;
      cls_i = 1; pspace_i = 1; #1;
      `CHK(illegal_o, 1'b1)
      step; valid_i = 0; pspace_i = 0;
      `CHK({pointer_zero_o, pointer_three_o}, {16'h0002, 16'hfffe})
   endtask
   task t_store;
      valid_i = 1; cls_i = 1; alu_op_i = 1; alu_dst_i = 0; alu_src_i = 1;
      write1_i = 1; reg1_i = 0; upd1_i = 3; #1;
      `CHK({xwr1_o, xrd1_o, xrd2_o}, 3'h4)
      `CHK(core_global_data_bus_o, mv(16'h0001))
      step; valid_i = 0; write1_i = 0;
      `CHK(reg0_o, mv(16'h0001) + mv(16'hffff))
   endtask
   task t_modes;
      valid_i = 1; cls_i = 3;
      for (int m = 0; m < 8; m++) begin
         amode_i = m[2:0]; #1;
         `CHK(illegal_o, m == 7)
         step;
      end
      pspace_i = 1; amode_i = 1; #1;
      `CHK({prd_o, xrd1_o}, 2'h2)
      `CHK(prog_addr_o, 16'h0002)
      step; write1_i = 1; #1;
      `CHK({pwr_o, prd_o, xwr1_o}, 3'h4)
      `CHK({prog_addr_o, prog_data_o}, {16'h0003, mv(16'h0002)})
      step; valid_i = 0; pspace_i = 0; write1_i = 0;
      `CHK(pointer_zero_o, 16'h0004)
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 0;
      t_dual; t_refuse; t_store; t_modes;
      close_out;
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      num_errors++;
      close_out;
   end
endmodule
bind pmx_core pmx_core_properties u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .valid_i(valid_i), .write1_i(write1_i),
   .accept_o(accept_o), .illegal_o(illegal_o), .xrd1_o(xrd1_o),
   .xwr1_o(xwr1_o), .xrd2_o(xrd2_o), .prd_o(prd_o), .pwr_o(pwr_o),
   .cls_i(cls_i), .amode_i(amode_i), .alu_op_i(alu_op_i), .upd2_i(upd2_i),
   .reg1_i(reg1_i), .reg2_i(reg2_i),
   .core_global_data_bus_i(core_global_data_bus_i),
   .secondary_data_bus_i(secondary_data_bus_i),
   .core_global_data_bus_o(core_global_data_bus_o), .reg0_o(reg0_o),
   .reg1_o(reg1_o), .pointer_three_o(pointer_three_o));
`default_nettype wire

// File: sim/pmx_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pmx_core_properties (
   input wire        clk_i, rst_i, valid_i, write1_i, accept_o, illegal_o,
   input wire        xrd1_o, xwr1_o, xrd2_o, prd_o, pwr_o,
   input wire [2:0]  cls_i, amode_i,
   input wire [1:0]  alu_op_i, upd2_i, reg1_i, reg2_i,
   input wire [15:0] core_global_data_bus_i, secondary_data_bus_i,
   input wire [15:0] core_global_data_bus_o, reg0_o, reg1_o, pointer_three_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire dual = valid_i && cls_i == 3'h2 && accept_o;
   wire spm = valid_i && cls_i == 3'h1;
   a_refused_quiet: assert property (illegal_o |->
      !(xrd1_o | xwr1_o | xrd2_o | prd_o | pwr_o | accept_o)) else $error("moved");
   a_jump_refused: assert property (valid_i && cls_i >= 3'h4 |-> illegal_o)
      else $error("no-move class taken");
   a_spm_no_nop: assert property (spm && alu_op_i == 2'h0 |-> illegal_o)
      else $error("move without alu op");
   a_spm_one_access: assert property (spm && accept_o |->
      (xrd1_o ^ xwr1_o) && !xrd2_o) else $error("single move access");
   a_dual_both: assert property (dual |-> xrd1_o && xrd2_o && !xwr1_o)
      else $error("dual read buses");
   a_dual_dest: assert property (dual && reg1_i == 2'h0 && reg2_i == 2'h1 |=>
      reg0_o == $past(core_global_data_bus_i) &&
      reg1_o == $past(secondary_data_bus_i)) else $error("dual dest");
   a_ptr_dec: assert property (dual && upd2_i == 2'h2 |=>
      pointer_three_o == $past(pointer_three_o) - 16'h1) else $error("ptr");
   a_store_old: assert property (spm && accept_o && write1_i &&
      reg1_i == 2'h0 |-> core_global_data_bus_o == reg0_o) else $error("store");
   a_mode_seven: assert property (valid_i && cls_i == 3'h3 &&
      amode_i == 3'h7 |-> illegal_o) else $error("mode seven taken");
   a_dual_no_ofs: assert property (valid_i && cls_i == 3'h2 &&
      upd2_i == 2'h3 |-> illegal_o) else $error("offset second read taken");
   c_dual: cover property (dual);
   c_store: cover property (spm && xwr1_o);
   c_refuse: cover property (illegal_o);
endmodule
`default_nettype wire

// File: sim/pmx_xmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmx_xmem_model (
   input  wire        rd1_i, rd2_i, prd_i,
   input  wire [15:0] a1_i, a2_i, pa_i,
   output wire [15:0] d1_o, d2_o, pd_o
);
   function [15:0] mv(input [15:0] a);
      mv = {a[7:0], ~a[15:8]};
   endfunction
   // Unselected buses show the complement, so stale data never matches.
   assign d1_o = rd1_i ? mv(a1_i) : ~mv(a1_i);
   assign d2_o = rd2_i ? mv(a2_i) : ~mv(a2_i);
   assign pd_o = prd_i ? mv(pa_i) : ~mv(pa_i);
endmodule
`default_nettype wire

// File: src/pmx_agu.v
`timescale 1ns/1ps
`default_nettype none
`include "pmx_regs.vh"
// Post-update arithmetic for one pointer.
module pmx_agu #(
   parameter AW = 16
) (
   input  wire [AW-1:0] ptr_i,
   input  wire [AW-1:0] ofs_i,
   input  wire [1:0]    upd_i,
   output reg  [AW-1:0] next_o
);
   always @* begin
      case (upd_i)
         `PMX_UPD_INC: next_o = ptr_i + {{(AW-1){1'b0}}, 1'b1};
         `PMX_UPD_DEC: next_o = ptr_i - {{(AW-1){1'b0}}, 1'b1};
         `PMX_UPD_OFS: next_o = ptr_i + ofs_i;
         default:      next_o = ptr_i;
      endcase
   end
endmodule
`default_nettype wire

// File: src/pmx_core.v
`timescale 1ns/1ps
`default_nettype none
`include "pmx_regs.vh"
// One-cycle execution of an ALU operation with its moves. A request is taken
// when valid_i is high and the decode does not refuse it; memory answers combinationally in the same cycle.
module pmx_core #(
   parameter DW = 16,
   parameter AW = 16
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          valid_i,
   input  wire [2:0]    cls_i,
   input  wire [1:0]    alu_op_i,
   input  wire [1:0]    alu_dst_i,
   input  wire [1:0]    alu_src_i,
   input  wire [1:0]    ptr1_sel_i,
   input  wire [1:0]    upd1_i,
   input  wire [1:0]    reg1_i,
   input  wire          write1_i,
   input  wire          pspace_i,
   input  wire [2:0]    amode_i,
   input  wire [AW-1:0] abs_addr_i,
   input  wire [1:0]    upd2_i,
   input  wire [1:0]    reg2_i,
   input  wire [DW-1:0] core_global_data_bus_i,
   input  wire [DW-1:0] secondary_data_bus_i,
   input  wire [DW-1:0] prog_data_i,
   output reg  [AW-1:0] primary_data_address_bus_o,
   output reg           xrd1_o,
   output reg           xwr1_o,
   output reg  [DW-1:0] core_global_data_bus_o,
   output reg  [AW-1:0] secondary_data_address_bus_o,
   output reg           xrd2_o,
   output reg  [AW-1:0] prog_addr_o,
   output reg           prd_o,
   output reg           pwr_o,
   output reg  [DW-1:0] prog_data_o,
   output reg           accept_o,
   output reg           illegal_o,
   output reg  [DW-1:0] reg0_o,
   output reg  [DW-1:0] reg1_o,
   output reg  [AW-1:0] pointer_zero_o,
   output reg  [AW-1:0] pointer_three_o
);
   reg [DW-1:0] dreg_q [0:`PMX_NREG-1];
   reg [AW-1:0] ptr_q  [0:`PMX_NPTR-1];
   // Offset register: no load path here, so it holds its reset value.
   reg [AW-1:0] ofs_q;
   reg [AW-1:0] ptr1;
   reg [AW-1:0] ptr2;
   reg [AW-1:0] ea1;
   reg [1:0]    upd1;
   reg          is_par;
   reg          is_spm;
   reg          is_dpr;
   reg          is_mov;
   reg          ok;
   reg [DW-1:0] alu_res;
   reg [DW-1:0] rd1;
   wire [AW-1:0] nxt1;
   wire [AW-1:0] nxt2;
   integer i;

   function [DW-1:0] alu_f;
      input [1:0]    op;
      input [DW-1:0] a;
      input [DW-1:0] b;
      begin
         case (op)
            `PMX_ALU_ADD: alu_f = a + b;
            `PMX_ALU_SUB: alu_f = a - b;
            // The multiply-accumulate is reduced to an add here.
            `PMX_ALU_MAC: alu_f = a + b[DW-1:0];
            default:      alu_f = a;
         endcase
      end
   endfunction

   // True for the classes whose first access runs through pointer unit one.
   function first_access_f;
      input [2:0] cls;
      begin
         first_access_f = (cls == `PMX_CLS_SPM) || (cls == `PMX_CLS_DPR) ||
                          (cls == `PMX_CLS_MOVE);
      end
   endfunction

   // Unit one serves any pointer; unit two only walks pointer three.
   pmx_agu #(.AW(AW)) u_agu1 (
      .ptr_i  (ptr1),
      .ofs_i  (ofs_q),
      .upd_i  (upd1),
      .next_o (nxt1)
   );
   pmx_agu #(.AW(AW)) u_agu2 (
      .ptr_i  (ptr2),
      .ofs_i  (ofs_q),
      .upd_i  (upd2_i),
      .next_o (nxt2)
   );

   // Instruction decode and refusal.
   always @* begin
      is_spm = valid_i && (cls_i == `PMX_CLS_SPM);
      is_dpr = valid_i && (cls_i == `PMX_CLS_DPR);
      is_mov = valid_i && (cls_i == `PMX_CLS_MOVE);
      is_par = is_spm || is_dpr;
      // Parallel forms need a real ALU op and a pointer update mode.
      ok = 1'b1;
      if (is_par && (alu_op_i == `PMX_ALU_NOP)) begin
         ok = 1'b0;
      end
      if (is_par && (upd1_i == `PMX_UPD_NONE)) begin
         ok = 1'b0;
      end
      // Second read uses only pointer three, never an offset update.
      if (is_dpr && ((upd2_i == `PMX_UPD_NONE) ||
                     (upd2_i == `PMX_UPD_OFS) || write1_i || pspace_i)) begin
         ok = 1'b0;
      end
      if (is_spm && pspace_i) begin
         ok = 1'b0;
      end
      if (is_mov && (amode_i == `PMX_AM_COUNT)) begin
         ok = 1'b0;
      end
      if (is_mov && pspace_i && (amode_i != `PMX_AM_IND) &&
          (amode_i != `PMX_AM_POSTINC)) begin
         ok = 1'b0;
      end
      if (valid_i && ((cls_i == `PMX_CLS_JUMP) || (cls_i == `PMX_CLS_LEA) ||
          (cls_i == `PMX_CLS_BIT_FIELD_SET_OP) || (cls_i == `PMX_CLS_BAD))) begin
         ok = 1'b0;
      end
      // A refused request drives no strobe and changes no state.
      accept_o  = valid_i && ok;
      illegal_o = valid_i && !ok;
   end

   // Pointer selection, effective address and access strobes.
   always @* begin
      ptr1 = ptr_q[ptr1_sel_i];
      ptr2 = ptr_q[`PMX_PAR_PTR_MAX];
      // Standalone modes map to the same post-update codes.
      upd1 = upd1_i;
      ea1  = ptr1;
      if (is_mov) begin
         case (amode_i)
            `PMX_AM_POSTINC: upd1 = `PMX_UPD_INC;
            `PMX_AM_POSTDEC: upd1 = `PMX_UPD_DEC;
            `PMX_AM_POSTOFS: upd1 = `PMX_UPD_OFS;
            `PMX_AM_IDXOFS: begin
               upd1 = `PMX_UPD_NONE;
               ea1  = ptr1 + ofs_q;
            end
            `PMX_AM_IDXIMM: begin
               upd1 = `PMX_UPD_NONE;
               ea1  = ptr1 + abs_addr_i;
            end
            `PMX_AM_ABS: begin
               upd1 = `PMX_UPD_NONE;
               ea1  = abs_addr_i;
            end
            default: upd1 = `PMX_UPD_NONE;
         endcase
      end
      primary_data_address_bus_o   = ea1;
      secondary_data_address_bus_o = ptr2;
      prog_addr_o = ea1;
      xrd1_o = accept_o && first_access_f(cls_i) && !write1_i && !pspace_i;
      xwr1_o = accept_o && first_access_f(cls_i) && write1_i && !pspace_i;
      xrd2_o = accept_o && is_dpr;
      prd_o  = accept_o && is_mov && pspace_i && !write1_i;
      pwr_o  = accept_o && is_mov && pspace_i && write1_i;
   end

   // Store data, read data selection, ALU result and state views.
   always @* begin
      // Stores take the register before this cycle's ALU write-back.
      core_global_data_bus_o = dreg_q[reg1_i];
      prog_data_o            = dreg_q[reg1_i];
      // Program reads use their own data bus; other first-access reads the global bus.
      rd1 = pspace_i ? prog_data_i : core_global_data_bus_i;
      alu_res = alu_f(alu_op_i, dreg_q[alu_dst_i], dreg_q[alu_src_i]);
      reg0_o = dreg_q[0];
      reg1_o = dreg_q[1];
      pointer_zero_o  = ptr_q[0];
      pointer_three_o = ptr_q[`PMX_PAR_PTR_MAX];
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < `PMX_NREG; i = i + 1) begin
            dreg_q[i] <= {DW{1'b0}};
         end
         for (i = 0; i < `PMX_NPTR; i = i + 1) begin
            ptr_q[i]  <= {AW{1'b0}};
         end
         ofs_q <= {AW{1'b0}};
      end else if (accept_o) begin
         // Later assignments win: a read into the ALU destination overrides
         // the ALU result, and unit two's update of pointer three is kept.
         if (is_par && (alu_op_i != `PMX_ALU_NOP)) begin
            dreg_q[alu_dst_i] <= alu_res;
         end
         if (!write1_i && first_access_f(cls_i)) begin
            dreg_q[reg1_i] <= rd1;
         end
         if (is_dpr) begin
            dreg_q[reg2_i] <= secondary_data_bus_i;
         end
         if (first_access_f(cls_i)) begin
            ptr_q[ptr1_sel_i] <= nxt1;
         end
         if (is_dpr) begin
            ptr_q[`PMX_PAR_PTR_MAX] <= nxt2;
         end
      end
   end
endmodule
`default_nettype wire

// File: src/pmx_regs.vh
`ifndef PMX_REGS_VH
`define PMX_REGS_VH
// Instruction classes.
`define PMX_CLS_ALU      3'h0
`define PMX_CLS_SPM      3'h1
`define PMX_CLS_DPR      3'h2
`define PMX_CLS_MOVE     3'h3
`define PMX_CLS_JUMP     3'h4
`define PMX_CLS_LEA      3'h5
`define PMX_CLS_BIT_FIELD_SET_OP    3'h6
`define PMX_CLS_BAD      3'h7
// Pointer update codes.
`define PMX_UPD_NONE     2'h0
`define PMX_UPD_INC      2'h1
`define PMX_UPD_DEC      2'h2
`define PMX_UPD_OFS      2'h3
// Standalone addressing modes (seven).
`define PMX_AM_IND       3'h0
`define PMX_AM_POSTINC   3'h1
`define PMX_AM_POSTDEC   3'h2
`define PMX_AM_POSTOFS   3'h3
`define PMX_AM_IDXOFS    3'h4
`define PMX_AM_IDXIMM    3'h5
`define PMX_AM_ABS       3'h6
`define PMX_AM_COUNT     3'h7
// ALU operations.
`define PMX_ALU_NOP      2'h0
`define PMX_ALU_ADD      2'h1
`define PMX_ALU_SUB      2'h2
`define PMX_ALU_MAC      2'h3
// Data ALU register file: four 16-bit registers; parallel subset is 0..3.
`define PMX_NREG         4
`define PMX_NPTR         4
`define PMX_PAR_PTR_MAX  2'h3
`endif
